// file: hw/ftc_ctrl.sv
`timescale 1ns/1ns
// Notes on behaviour
// - nonzero channel B output mode hands the pin to the compare output
// - complementary B pin driven only in PWM with mode 01
// - B mode meaning follows B PWM enable and low wave-mode bit
// - non-PWM: 01 toggle, 10 clear, 11 set on match
// - fast PWM: 01/10 clear on match, set at zero; 11 opposite
// - phase-correct: 01/10 clear on up match, set on down; 11 inverted
// - force A acts only when A is non-PWM
// - force applies match action using same-cycle written mode bits
// - force raises no interrupt; force A reads zero
// - force B acts non-PWM only, no interrupt, reads zero
// - PWM enables put each channel in PWM on its own compare
// - inversion bit inverts all dead-time generator outputs
// - prescaler reset self-clears, leaves count, reads zero
// - dead-time prescaler divides by 1, 2, 4 or 8
// - clock select zero stops; n selects source divided by 2**(n-1)
// - zero clock select disables the timer, nonzero enables
// - shadow register holds copies of A and B output modes
// - wave mode: fast, phase-correct, six-output single, six-output dual
module ftc_ctrl (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    clk_en,
    // register port
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // configuration
    input  wire logic                    async_src,
    input  wire logic                    fast_periph_clock,
    input  wire logic [1:0]              wave_mode,
    // counter events, same clock
    input  wire ftc_pkg::ftc_event_s     evt,
    input  wire ftc_pkg::ftc_dt_s        dt_in,
    // timer side
    output logic                         count_tick,
    output logic                         count_enable,
    output logic                         deadtime_tick,
    // pins
    output logic                         chan_a_waveform,
    output logic                         chan_b_waveform,
    output logic                         chan_a_compare_pin_sel,
    output logic                         chan_b_compare_pin_sel,
    output logic                         chan_b_comp_pin_sel,
    output ftc_pkg::ftc_dt_s             pin_out
);
    typedef struct packed {
        logic [7:0]               modes;
        logic [7:0]               clkdt;
        logic [7:0]               shadow;
        logic [7:0]               rdata;
        logic                     fpck_s1;
        logic                     fpck_s2;
        logic                     fpck_s3;
        logic                     async_s1;
        logic                     async_s2;
        logic                     pre_clear;
        logic [ftc_pkg::DT_WIDTH-1:0] dt_cnt;
        logic                     dt_tick;
        logic                     wave_a;
        logic                     wave_b;
        logic                     sel_a;
        logic                     sel_b;
        logic                     sel_bc;
        logic                     enable;
        ftc_pkg::ftc_dt_s         pins;
        ftc_pkg::ftc_run_e        run;
    } ftc_state_s;

    ftc_state_s st_reg;
    ftc_state_s st_next;
    logic       src_tick;
    logic       pre_tick;
    logic [7:0] modes_eff;

    ftc_prescaler u_pre (
        .clk      (clk),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .clear    (st_reg.pre_clear),
        .src_tick (src_tick),
        .sel      (st_reg.clkdt[ftc_pkg::CS_HI:ftc_pkg::CS_LO]),
        .tick     (pre_tick)
    );

    // async source: rising edges of the synchronised fast clock
    assign src_tick = st_reg.async_s2 ? (st_reg.fpck_s2 & ~st_reg.fpck_s3) : 1'b1;

    function automatic logic next_wave(input logic cur, input logic [1:0] om,
                                       input logic pwm, input logic [1:0] wm,
                                       input logic match, input logic zero,
                                       input logic up, input logic force_it);
        logic w;
        w = cur;
        if (!pwm) begin
            if (match || force_it) begin
                case (om)
                    ftc_pkg::OM_TOGGLE: w = ~cur;
                    ftc_pkg::OM_CLEAR:  w = 1'b0;
                    ftc_pkg::OM_SET:    w = 1'b1;
                    default:            w = cur;
                endcase
            end
        end else if (om != ftc_pkg::OM_PORT) begin
            if (wm[0] == 1'b0) begin
                // fast and single-slope six-output
                if (match) begin
                    w = (om == ftc_pkg::OM_SET);
                end else if (zero) begin
                    w = (om != ftc_pkg::OM_SET);
                end
            end else if (match) begin
                // phase and frequency correct, dual-slope
                w = (om == ftc_pkg::OM_SET) ? up : ~up;
            end
        end
        return w;
    endfunction

    always_comb begin
        st_next = st_reg;
        st_next.fpck_s1 = fast_periph_clock;
        st_next.fpck_s2 = st_reg.fpck_s1;
        st_next.fpck_s3 = st_reg.fpck_s2;
        st_next.async_s1 = async_src;
        st_next.async_s2 = st_reg.async_s1;
        st_next.pre_clear = 1'b0;
        modes_eff = st_reg.modes;

        if (reg_wr) begin
            case (reg_addr)
                ftc_pkg::OFS_COMPARE_MODES: begin
                    // strobes are never stored
                    st_next.modes = reg_wdata & 8'hf3;
                    modes_eff = reg_wdata;
                    st_next.shadow[7:4] = reg_wdata[7:4];
                end
                ftc_pkg::OFS_CLOCK_DEADTIME: begin
                    st_next.clkdt = reg_wdata & 8'hbf;
                    st_next.pre_clear = reg_wdata[ftc_pkg::PRE_RST];
                end
                ftc_pkg::OFS_SHADOW_MODES: begin
                    st_next.shadow = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        st_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ftc_pkg::OFS_COMPARE_MODES:  st_next.rdata = st_reg.modes;
                ftc_pkg::OFS_CLOCK_DEADTIME: st_next.rdata = st_reg.clkdt;
                ftc_pkg::OFS_SHADOW_MODES:   st_next.rdata = st_reg.shadow;
                ftc_pkg::OFS_STATUS: begin
                    st_next.rdata = {3'h0, st_reg.run, st_reg.wave_a, st_reg.wave_b};
                end
                default: st_next.rdata = 8'h00;
            endcase
        end

        // waveform update; match events and forces never raise interrupts
        st_next.wave_a = next_wave(st_reg.wave_a,
            modes_eff[ftc_pkg::A_MODE_HI:ftc_pkg::A_MODE_LO],
            modes_eff[ftc_pkg::PWM_A], wave_mode, evt.a_match, evt.zero, evt.up,
            reg_wr && reg_addr == ftc_pkg::OFS_COMPARE_MODES
                && modes_eff[ftc_pkg::FORCE_A] && !modes_eff[ftc_pkg::PWM_A]);
        st_next.wave_b = next_wave(st_reg.wave_b,
            modes_eff[ftc_pkg::B_MODE_HI:ftc_pkg::B_MODE_LO],
            modes_eff[ftc_pkg::PWM_B], wave_mode, evt.b_match, evt.zero, evt.up,
            reg_wr && reg_addr == ftc_pkg::OFS_COMPARE_MODES
                && modes_eff[ftc_pkg::FORCE_B] && !modes_eff[ftc_pkg::PWM_B]);

        st_next.sel_a = |modes_eff[ftc_pkg::A_MODE_HI:ftc_pkg::A_MODE_LO];
        st_next.sel_b = |modes_eff[ftc_pkg::B_MODE_HI:ftc_pkg::B_MODE_LO];
        st_next.sel_bc = modes_eff[ftc_pkg::PWM_B]
            && modes_eff[ftc_pkg::B_MODE_HI:ftc_pkg::B_MODE_LO] == ftc_pkg::OM_TOGGLE;

        // inversion of every dead-time output
        st_next.pins = st_reg.clkdt[ftc_pkg::INVERT] ? ~dt_in : dt_in;

        // dead-time divider 1/2/4/8
        st_next.dt_tick = 1'b0;
        if (pre_tick) begin
            st_next.dt_cnt = st_reg.dt_cnt + 3'h1;
            case (st_reg.clkdt[ftc_pkg::DT_HI:ftc_pkg::DT_LO])
                2'h0:    st_next.dt_tick = 1'b1;
                2'h1:    st_next.dt_tick = st_reg.dt_cnt[0];
                2'h2:    st_next.dt_tick = &st_reg.dt_cnt[1:0];
                default: st_next.dt_tick = &st_reg.dt_cnt;
            endcase
        end
        if (st_reg.pre_clear) begin
            st_next.dt_cnt = '0;
        end

        // run state follows the clock select
        case (st_reg.run)
            ftc_pkg::ST_STOPPED: begin
                if (st_reg.clkdt[ftc_pkg::CS_HI:ftc_pkg::CS_LO] != 4'h0) begin
                    st_next.run = ftc_pkg::ST_RUN;
                end
            end
            ftc_pkg::ST_RUN: begin
                if (st_reg.clkdt[ftc_pkg::CS_HI:ftc_pkg::CS_LO] == 4'h0) begin
                    st_next.run = ftc_pkg::ST_FLUSH;
                end
            end
            ftc_pkg::ST_FLUSH: st_next.run = ftc_pkg::ST_STOPPED;
            default:           st_next.run = ftc_pkg::ST_STOPPED;
        endcase
        st_next.enable = (st_next.run == ftc_pkg::ST_RUN);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.run <= ftc_pkg::ST_STOPPED;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata              = st_reg.rdata;
    assign count_tick             = pre_tick;
    assign count_enable           = st_reg.enable;
    assign deadtime_tick          = st_reg.dt_tick;
    assign chan_a_waveform        = st_reg.wave_a;
    assign chan_b_waveform        = st_reg.wave_b;
    assign chan_a_compare_pin_sel = st_reg.sel_a;
    assign chan_b_compare_pin_sel = st_reg.sel_b;
    assign chan_b_comp_pin_sel    = st_reg.sel_bc;
    assign pin_out                = st_reg.pins;
endmodule

// file: hw/ftc_pkg.sv
package ftc_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] OFS_COMPARE_MODES = 8'h30;
    localparam logic [7:0] OFS_CLOCK_DEADTIME = 8'h2f;
    localparam logic [7:0] OFS_SHADOW_MODES  = 8'h27;
    localparam logic [7:0] OFS_STATUS        = 8'h28;

    // compare-modes fields
    localparam int A_MODE_HI = 7;
    localparam int A_MODE_LO = 6;
    localparam int B_MODE_HI = 5;
    localparam int B_MODE_LO = 4;
    localparam int FORCE_A   = 3;
    localparam int FORCE_B   = 2;
    localparam int PWM_A     = 1;
    localparam int PWM_B     = 0;

    // clock/deadtime fields
    localparam int INVERT    = 7;
    localparam int PRE_RST   = 6;
    localparam int DT_HI     = 5;
    localparam int DT_LO     = 4;
    localparam int CS_HI     = 3;
    localparam int CS_LO     = 0;

    // shadow fields
    localparam int SH_A_HI   = 7;
    localparam int SH_A_LO   = 6;
    localparam int SH_B_HI   = 5;
    localparam int SH_B_LO   = 4;

    localparam logic [7:0]  RESET_BYTE  = 8'h00;
    localparam logic [9:0]  COUNT_ZERO  = 10'h000;
    localparam int          PRE_WIDTH   = 14;
    localparam int          DT_WIDTH    = 3;

    localparam logic [1:0] OM_PORT   = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR  = 2'h2;
    localparam logic [1:0] OM_SET    = 2'h3;

    localparam logic [1:0] WM_FAST   = 2'h0;
    localparam logic [1:0] WM_PFC    = 2'h1;
    localparam logic [1:0] WM_PWM6S  = 2'h2;
    localparam logic [1:0] WM_PWM6D  = 2'h3;

    typedef enum logic [2:0] {
        ST_STOPPED = 3'h1,
        ST_RUN     = 3'h2,
        ST_FLUSH   = 3'h4
    } ftc_run_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ftc_bus_s;

    typedef struct packed {
        logic       a_match;
        logic       b_match;
        logic       zero;
        logic       up;
    } ftc_event_s;

    typedef struct packed {
        logic       a_true;
        logic       a_comp;
        logic       b_true;
        logic       b_comp;
    } ftc_dt_s;
endpackage

// file: hw/ftc_prescaler.sv
`timescale 1ns/1ns
module ftc_prescaler (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        clk_en,
    // control
    input  wire logic                        clear,
    input  wire logic                        src_tick,
    input  wire logic [3:0]                  sel,
    // result
    output logic                             tick
);
    typedef struct packed {
        logic [ftc_pkg::PRE_WIDTH-1:0] cnt;
        logic                          tick;
    } ftc_pre_s;

    ftc_pre_s st_reg;
    ftc_pre_s st_next;
    logic [ftc_pkg::PRE_WIDTH-1:0] inc;
    logic [ftc_pkg::PRE_WIDTH-1:0] rise;

    always_comb begin
        st_next = st_reg;
        inc = st_reg.cnt + {{(ftc_pkg::PRE_WIDTH-1){1'b0}}, 1'b1};
        rise = inc & ~st_reg.cnt;
        st_next.tick = 1'b0;
        if (clear) begin
            st_next.cnt = '0;
        end else if (src_tick && sel != 4'h0) begin
            st_next.cnt = inc;
            // sel n divides the source by 2**(n-1)
            if (sel == 4'h1) begin
                st_next.tick = 1'b1;
            end else begin
                st_next.tick = rise[sel - 4'h2];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign tick = st_reg.tick;
endmodule

// file: sim/ftc_ctrl_checker.sv
`timescale 1ns/1ns
module ftc_ctrl_checker (
    // clock and reset
    input wire logic             clk,
    input wire logic             arst_n,
    input wire logic             clk_en,
    // register port
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    // timer and pins
    input wire ftc_pkg::ftc_dt_s dt_in,
    input wire logic             count_tick,
    input wire logic             count_enable,
    input wire logic             chan_a_waveform,
    input wire logic             chan_b_waveform,
    input wire logic             chan_b_compare_pin_sel,
    input wire logic             chan_b_comp_pin_sel,
    input wire ftc_pkg::ftc_dt_s pin_out
);
    logic wr_cm;
    logic wr_cd;
    logic inv_reg;
    assign wr_cm = clk_en && reg_wr && reg_addr == ftc_pkg::OFS_COMPARE_MODES;
    assign wr_cd = clk_en && reg_wr && reg_addr == ftc_pkg::OFS_CLOCK_DEADTIME;
    // mirror of the invert bit so the pin relation can be checked
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inv_reg <= 1'b0;
        end else if (wr_cd) begin
            inv_reg <= reg_wdata[ftc_pkg::INVERT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_force_rd_zero: assert property ($past(reg_rd && reg_addr == 8'h30) |->
        reg_rdata[3:2] == 2'h0) else $error("force bits read back nonzero");
    a_psr_rd_zero: assert property ($past(reg_rd && reg_addr == 8'h2f) |->
        !reg_rdata[6]) else $error("prescaler reset bit read back nonzero");
    a_b_pin_take: assert property (wr_cm |=>
        chan_b_compare_pin_sel == |$past(reg_wdata[5:4])) else $error("b pin select wrong");
    a_b_comp_pin: assert property (wr_cm |=> chan_b_comp_pin_sel ==
        ($past(reg_wdata[5:4]) == 2'h1 && $past(reg_wdata[0])))
        else $error("b complementary select wrong");
    a_force_b_act: assert property (wr_cm && reg_wdata[2] && !reg_wdata[0] && reg_wdata[5]
        |=> chan_b_waveform == $past(reg_wdata[4])) else $error("force b action wrong");
    a_force_a_act: assert property (wr_cm && reg_wdata[3] && !reg_wdata[1] && reg_wdata[7]
        |=> chan_a_waveform == $past(reg_wdata[6])) else $error("force a action wrong");
    // the run state follows a lone clock-select write two edges later
    a_count_en: assert property (!$past(wr_cd) && wr_cd ##1 !wr_cd |=>
        count_enable == |$past(reg_wdata[3:0], 2))
        else $error("count enable does not follow clock select");
    a_pin_invert: assert property ($past(arst_n) && $past(clk_en) |->
        pin_out == ($past(dt_in) ^ {4{$past(inv_reg)}}))
        else $error("pin outputs not dead-time outputs with inversion");
    a_stop_no_tick: assert property (!count_enable [*3] |-> !count_tick)
        else $error("tick while stopped");
    c_force: cover property (wr_cm && reg_wdata[2]);
    c_tick: cover property (count_tick);
    c_invert: cover property (inv_reg && dt_in != 4'h0);
endmodule
bind ftc_ctrl ftc_ctrl_checker i_chk (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dt_in(dt_in), .count_tick(count_tick),
    .count_enable(count_enable), .chan_a_waveform(chan_a_waveform),
    .chan_b_waveform(chan_b_waveform), .chan_b_compare_pin_sel(chan_b_compare_pin_sel),
    .chan_b_comp_pin_sel(chan_b_comp_pin_sel), .pin_out(pin_out));

// file: sim/ftc_ctrl_tb.sv
`timescale 1ns/1ns
module ftc_ctrl_tb;
    typedef struct packed {
        logic [7:0] wd;
        logic [1:0] wm;
        logic [3:0] ev;
        logic       wave;
        logic       bsel;
        logic       comp;
    } ftc_row_s;
    logic clk, arst_n, clk_en, reg_wr, reg_rd, async_src, fast_periph_clock;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0] wave_mode;
    ftc_pkg::ftc_event_s evt;
    ftc_pkg::ftc_dt_s dt_in, pin_out;
    logic count_tick, count_enable, deadtime_tick, a_wave, b_wave, a_sel, b_sel, b_comp;
    int n_mismatch, num_checks, cyc, cnt, dcnt, e;
    ftc_row_s rows [12];

    ftc_ctrl i_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .async_src(async_src), .fast_periph_clock(fast_periph_clock),
        .wave_mode(wave_mode), .evt(evt), .dt_in(dt_in), .count_tick(count_tick),
        .count_enable(count_enable), .deadtime_tick(deadtime_tick),
        .chan_a_waveform(a_wave), .chan_b_waveform(b_wave), .chan_a_compare_pin_sel(a_sel),
        .chan_b_compare_pin_sel(b_sel), .chan_b_comp_pin_sel(b_comp), .pin_out(pin_out));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            n_mismatch++;
        end
        num_checks++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic ev(input logic [3:0] x);
        @(posedge clk);
        evt <= x;
        @(posedge clk);
        evt <= 4'h0;
        #1;
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        fast_periph_clock <= ~fast_periph_clock;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        {arst_n, reg_wr, reg_rd, async_src, fast_periph_clock} = 5'h00;
        {reg_addr, reg_wdata, wave_mode, evt, dt_in} = 26'h0;
        clk_en = 1'b1;
        rows = '{{8'h21, 2'h0, 4'h2, 3'h6}, {8'h21, 2'h0, 4'h4, 3'h2},
                 {8'h31, 2'h0, 4'h4, 3'h6}, {8'h31, 2'h0, 4'h2, 3'h2},
                 {8'h11, 2'h1, 4'h5, 3'h3}, {8'h11, 2'h1, 4'h4, 3'h7},
                 {8'h31, 2'h1, 4'h5, 3'h6}, {8'h31, 2'h1, 4'h4, 3'h2},
                 {8'h10, 2'h0, 4'h4, 3'h6}, {8'h20, 2'h0, 4'h4, 3'h2},
                 {8'h30, 2'h0, 4'h4, 3'h6}, {8'h30, 2'h0, 4'h0, 3'h6}};
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk("count_enable", count_enable, 8'h00);
        rd(8'h2f, d);
        chk("clock_reg", d, 8'h00);
        rd(8'h27, d);
        chk("shadow_reg", d, 8'h00);
        // selects only request the pin; software owns its direction bit
        foreach (rows[i]) begin
            @(posedge clk);
            wave_mode <= rows[i].wm;
            wr(ftc_pkg::OFS_COMPARE_MODES, rows[i].wd);
            chk("b_pin_sel", b_sel, rows[i].bsel);
            chk("b_comp_sel", b_comp, rows[i].comp);
            ev(rows[i].ev);
            chk("b_wave", b_wave, rows[i].wave);
            rd(ftc_pkg::OFS_COMPARE_MODES, d);
            chk("modes_rd", d, rows[i].wd);
        end
        rd(8'h27, d);
        chk("shadow_copy", d, 8'h30);
        // force actions, including ones written while in pwm
        wr(8'h30, 8'h34);
        chk("force_b_set", b_wave, 8'h01);
        wr(8'h30, 8'h24);
        chk("force_b_clr", b_wave, 8'h00);
        wr(8'h30, 8'h35);
        chk("force_b_pwm", b_wave, 8'h00);
        rd(8'h30, d);
        chk("force_rd", d, 8'h31);
        wr(8'h30, 8'hc8);
        chk("force_a_set", a_wave, 8'h01);
        chk("a_pin_sel", a_sel, 8'h01);
        wr(8'h30, 8'h8a);
        chk("force_a_pwm", a_wave, 8'h01);
        rd(8'h30, d);
        chk("force_a_rd", d, 8'h82);
        // clock register, inversion and unmapped place
        @(posedge clk);
        dt_in <= 4'h5;
        wr(8'h2f, 8'hc1);
        // the run state needs one more edge to follow the clock select
        @(posedge clk);
        #1;
        chk("count_enable", count_enable, 8'h01);
        rd(8'h2f, d);
        chk("psr_rd", d, 8'h81);
        chk("pin_inv", pin_out, 8'h0a);
        wr(8'h55, 8'hff);
        rd(8'h55, d);
        chk("unmapped_rd", d, 8'h00);
        wr(8'h2f, 8'h00);
        @(posedge clk);
        #1;
        chk("count_stop", count_enable, 8'h00);
        chk("pin_plain", pin_out, 8'h05);
        // tick rates for both sources and three selections
        for (int s = 0; s < 2; s++) begin
            for (int n = 1; n < 4; n++) begin
                @(posedge clk);
                async_src <= s[0];
                wr(8'h2f, {4'h3, 4'(n)});
                repeat (8) @(posedge clk);
                cnt = 0;
                dcnt = 0;
                repeat (64) begin
                    @(posedge clk);
                    #1;
                    cnt += int'(count_tick);
                    dcnt += int'(deadtime_tick);
                end
                e = 64 >> (n - 1 + s);
                chk("tick_rate", 8'(cnt >= e - 2 && cnt <= e + 2), 8'h01);
                if (n == 1 && s == 0) chk("dt_rate", 8'(dcnt >= 7 && dcnt <= 9), 8'h01);
            end
        end
        rd(ftc_pkg::OFS_STATUS, d);
        chk("run_status", d, {3'h0, ftc_pkg::ST_RUN, 2'h2});
        // second reset in mid-run: state returns to its reset values
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk("rst_enable", count_enable, 8'h00);
        chk("rst_wave_a", a_wave, 8'h00);
        rd(ftc_pkg::OFS_CLOCK_DEADTIME, d);
        chk("rst_clock", d, 8'h00);
        rd(ftc_pkg::OFS_STATUS, d);
        chk("rst_status", d, {3'h0, ftc_pkg::ST_STOPPED, 2'h0});
        summarize();
    end
endmodule
